// file: pin_mux_cfg.svh
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// port a bit positions
`define PA_CMP_POS    0
`define PA_CMP_NEG    1
`define PA_RST_BIT    3
`define PA_SEL_BIT    4
`define PA_MOSI_BIT   5
`define PA_MISO_BIT   6
`define PA_SCK_BIT    7

// port b bit positions
`define PB_RXD_BIT    0
`define PB_OSC_IN     2
`define PB_OSC_OUT    3
`define PB_T1_BIT     5

// divided clock output ratio
`define CLK_DIV_RATIO 2

`endif

// file: pin_mux_pkg.sv
package pin_mux_pkg;

  typedef enum logic [1:0] {
    OSC_OUT_PORT,
    OSC_OUT_CLKDIV,
    OSC_OUT_AMP,
    OSC_OUT_DEBUG
  } osc_out_sel_e;

  typedef enum logic [1:0] {
    T1_PORT,
    T1_COUNT_IN,
    T1_PWM_OUT
  } t1_mode_e;

endpackage

// file: in_sync.sv
`timescale 1ns/1ps
module in_sync #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

// file: pin_function_mux.sv
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
// Behaviour
// - mosi pin drives out in spi master role and is an input in slave role.
// - sck pin is driven by us as master and by the external master as slave.
// - miso pin is an input as master and driven by us as slave.
// - with the rc oscillator, osc_out_pin is a port pin or clock divided by 2.
// - osc_out_pin carries the amplifier output when a crystal is in use and debug is off.
// - osc_in_pin feeds the amplifier unless the rc oscillator is selected.
// - debug with rc clock places debug_data_line on osc_in_pin.
// - debug with external clock places debug_data_line on osc_out_pin.
// - port_a_bit3 is active-low reset when the reset fuse is set and debug clock input when debug is on (both at once if both are set), else port.
// - port_b_bit5 is timer1 count input, timer1 pwm output, or port pin.
// - on the serial variant port_b_bit0 feeds the serial receiver.
// - port_a bits 0 and 1 feed the comparator positive and negative inputs.
// - every port_a pin also feeds its own pin_interrupt_in.
module pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int  PA_W       = 8,
  parameter int  PB_W       = 6,
  parameter bit  HAS_SERIAL = 1'b1
) (
  input  wire logic            i_mclk,
  input  wire logic            i_arst_n,
  // configuration
  input  wire logic            i_spi_en,
  input  wire logic            i_spi_master,
  input  wire logic            i_rc_osc_sel,
  input  wire logic            i_divided_clock_output_en,
  input  wire logic            i_debug_en,
  input  wire logic            i_reset_fuse,
  input  wire logic            i_cmp_en,
  input  wire logic            i_serial_en,
  input  wire t1_mode_e        i_t1_mode,
  // general port logic
  input  wire logic [PA_W-1:0] i_pa_out,
  input  wire logic [PA_W-1:0] i_pa_oe_n,
  input  wire logic [PB_W-1:0] i_pb_out,
  input  wire logic [PB_W-1:0] i_pb_oe_n,
  output logic      [PA_W-1:0] o_pa_in,
  output logic      [PB_W-1:0] o_pb_in,
  // peripherals
  input  wire logic            i_spi_mosi,
  input  wire logic            i_spi_sck,
  input  wire logic            i_spi_miso,
  output logic                 o_spi_mosi,
  output logic                 o_spi_sck,
  output logic                 o_spi_miso,
  output logic                 o_spi_sel_n,
  input  wire logic            i_osc_amp_out,
  output logic                 o_osc_amp_in,
  input  wire logic            i_debug_data,
  input  wire logic            i_debug_data_oe_n,
  output logic                 o_debug_data,
  output logic                 o_debug_clk,
  output logic                 o_ext_reset_n,
  input  wire logic            i_t1_pwm,
  output logic                 o_t1_count,
  output logic                 o_serial_rx,
  output logic                 o_cmp_pos,
  output logic                 o_cmp_neg,
  output logic      [PA_W-1:0] o_pin_interrupt_in,
  // pads
  input  wire logic [PA_W-1:0] i_pa_pad,
  output logic      [PA_W-1:0] o_pa_pad,
  output logic      [PA_W-1:0] o_pa_pad_oe_n,
  input  wire logic [PB_W-1:0] i_pb_pad,
  output logic      [PB_W-1:0] o_pb_pad,
  output logic      [PB_W-1:0] o_pb_pad_oe_n
);

  // ***********************************************************
  // pad input synchronisers
  // ***********************************************************
  logic [PA_W-1:0] pa_s;
  logic [PB_W-1:0] pb_s;

  in_sync #(.W(PA_W)) u_pa_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_d      (i_pa_pad),
    .o_q      (pa_s)
  );

  in_sync #(.W(PB_W)) u_pb_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_d      (i_pb_pad),
    .o_q      (pb_s)
  );

  // ***********************************************************
  // divided clock output
  // ***********************************************************
  logic div_q;
  logic div_d;

  // divide by 2 toggles every rising edge of i_mclk; held low when not in use
  assign div_d = (i_rc_osc_sel && i_divided_clock_output_en) ? ~div_q : 1'b0;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= 1'b0;
    end else begin
      div_q <= div_d;
    end
  end

  // ***********************************************************
  // selection
  // ***********************************************************
  wire          spi_mst  = i_spi_en && i_spi_master;
  wire          spi_slv  = i_spi_en && !i_spi_master;
  wire          dbg_in   = i_debug_en && i_rc_osc_sel;
  wire          dbg_out  = i_debug_en && !i_rc_osc_sel;
  wire          t1_pwm   = (i_t1_mode == T1_PWM_OUT);
  wire          t1_cnt   = (i_t1_mode == T1_COUNT_IN);
  wire          serial_on = HAS_SERIAL && i_serial_en;
  osc_out_sel_e osc_sel;

  // debug beats the crystal amplifier; crystal amplifier beats the divided clock output
  assign osc_sel = dbg_out                    ? OSC_OUT_DEBUG  :
                   !i_rc_osc_sel              ? OSC_OUT_AMP    :
                   i_divided_clock_output_en                ? OSC_OUT_CLKDIV :
                                                OSC_OUT_PORT;

  // ***********************************************************
  // port a drive
  // ***********************************************************
  logic [PA_W-1:0] pa_alt_oe;
  logic [PA_W-1:0] pa_alt_out;
  logic [PA_W-1:0] pa_alt_own;

  genvar ga;
  generate
    for (ga = 0; ga < PA_W; ga++) begin : g_pa
      if (ga == `PA_MOSI_BIT) begin : g_mosi
        assign pa_alt_own[ga] = i_spi_en;
        assign pa_alt_oe[ga]  = spi_mst;
        assign pa_alt_out[ga] = i_spi_mosi;
      end else if (ga == `PA_MISO_BIT) begin : g_miso
        assign pa_alt_own[ga] = i_spi_en;
        assign pa_alt_oe[ga]  = spi_slv;
        assign pa_alt_out[ga] = i_spi_miso;
      end else if (ga == `PA_SCK_BIT) begin : g_sck
        assign pa_alt_own[ga] = i_spi_en;
        assign pa_alt_oe[ga]  = spi_mst;
        assign pa_alt_out[ga] = i_spi_sck;
      end else if (ga == `PA_RST_BIT) begin : g_rst
        // reset or debug clock pins are inputs only
        assign pa_alt_own[ga] = i_reset_fuse || i_debug_en;
        assign pa_alt_oe[ga]  = 1'b0;
        assign pa_alt_out[ga] = 1'b0;
      end else if (ga == `PA_SEL_BIT) begin : g_sel
        assign pa_alt_own[ga] = spi_slv;
        assign pa_alt_oe[ga]  = 1'b0;
        assign pa_alt_out[ga] = 1'b0;
      end else if (ga == `PA_CMP_POS || ga == `PA_CMP_NEG) begin : g_cmp
        // analog inputs must not be loaded by the port driver
        assign pa_alt_own[ga] = i_cmp_en;
        assign pa_alt_oe[ga]  = 1'b0;
        assign pa_alt_out[ga] = 1'b0;
      end else begin : g_plain
        assign pa_alt_own[ga] = 1'b0;
        assign pa_alt_oe[ga]  = 1'b0;
        assign pa_alt_out[ga] = 1'b0;
      end
      assign o_pa_pad[ga]      = pa_alt_own[ga] ? pa_alt_out[ga]
                                                : i_pa_out[ga];
      assign o_pa_pad_oe_n[ga] = pa_alt_own[ga] ? ~pa_alt_oe[ga]
                                                : i_pa_oe_n[ga];
    end
  endgenerate

  // ***********************************************************
  // port b drive
  // ***********************************************************
  logic [PB_W-1:0] pb_alt_own;
  logic [PB_W-1:0] pb_alt_oe;
  logic [PB_W-1:0] pb_alt_out;

  genvar gb;
  generate
    for (gb = 0; gb < PB_W; gb++) begin : g_pb
      if (gb == `PB_OSC_IN) begin : g_oin
        assign pb_alt_own[gb] = !i_rc_osc_sel || dbg_in;
        assign pb_alt_oe[gb]  = dbg_in && !i_debug_data_oe_n;
        assign pb_alt_out[gb] = i_debug_data;
      end else if (gb == `PB_OSC_OUT) begin : g_oout
        assign pb_alt_own[gb] = (osc_sel != OSC_OUT_PORT);
        assign pb_alt_oe[gb]  = (osc_sel == OSC_OUT_DEBUG)
                                ? !i_debug_data_oe_n : 1'b1;
        assign pb_alt_out[gb] = (osc_sel == OSC_OUT_DEBUG) ? i_debug_data :
                                (osc_sel == OSC_OUT_AMP)   ? i_osc_amp_out :
                                div_q;
      end else if (gb == `PB_T1_BIT) begin : g_t1
        // count mode claims the pin as input so port drive cannot mask it
        assign pb_alt_own[gb] = t1_pwm || t1_cnt;
        assign pb_alt_oe[gb]  = t1_pwm;
        assign pb_alt_out[gb] = i_t1_pwm;
      end else if (gb == `PB_RXD_BIT) begin : g_rxd
        assign pb_alt_own[gb] = serial_on;
        assign pb_alt_oe[gb]  = 1'b0;
        assign pb_alt_out[gb] = 1'b0;
      end else begin : g_plain
        assign pb_alt_own[gb] = 1'b0;
        assign pb_alt_oe[gb]  = 1'b0;
        assign pb_alt_out[gb] = 1'b0;
      end
      assign o_pb_pad[gb]      = pb_alt_own[gb] ? pb_alt_out[gb]
                                                : i_pb_out[gb];
      assign o_pb_pad_oe_n[gb] = pb_alt_own[gb] ? ~pb_alt_oe[gb]
                                                : i_pb_oe_n[gb];
    end
  endgenerate

  // ***********************************************************
  // inputs towards the peripherals
  // ***********************************************************
  // pin value always visible to the port register, even when borrowed
  assign o_pa_in = pa_s;
  assign o_pb_in = pb_s;

  assign o_spi_mosi  = spi_slv ? pa_s[`PA_MOSI_BIT] : 1'b0;
  assign o_spi_sck   = spi_slv ? pa_s[`PA_SCK_BIT]  : 1'b0;
  assign o_spi_miso  = spi_mst ? pa_s[`PA_MISO_BIT] : 1'b0;
  // deselected unless slave role, so a floating pin never selects
  assign o_spi_sel_n = spi_slv ? pa_s[`PA_SEL_BIT]  : 1'b1;

  // amplifier input is raw: a clock path must not see sync delay
  assign o_osc_amp_in = !i_rc_osc_sel ? i_pb_pad[`PB_OSC_IN] : 1'b0;

  assign o_debug_data = dbg_in  ? pb_s[`PB_OSC_IN]  :
                        dbg_out ? pb_s[`PB_OSC_OUT] : 1'b1;
  // debug clock is only sampled; it is slow next to i_mclk
  assign o_debug_clk  = i_debug_en ? pa_s[`PA_RST_BIT] : 1'b0;

  assign o_ext_reset_n = i_reset_fuse ? pa_s[`PA_RST_BIT] : 1'b1;

  assign o_t1_count  = (i_t1_mode == T1_COUNT_IN)
                       ? pb_s[`PB_T1_BIT] : 1'b0;
  assign o_serial_rx = serial_on ? pb_s[`PB_RXD_BIT] : 1'b1;

  assign o_cmp_pos = i_cmp_en ? pa_s[`PA_CMP_POS] : 1'b0;
  assign o_cmp_neg = i_cmp_en ? pa_s[`PA_CMP_NEG] : 1'b0;

  assign o_pin_interrupt_in = pa_s;

endmodule

// file: pin_mux_chk_assertions.sv
`timescale 1ns/1ps
// ****************
// pin mux checker
// ****************
module pin_mux_chk (
  input wire logic       i_mclk,
  input wire logic       i_arst_n,
  input wire logic       i_spi_en,
  input wire logic       i_spi_master,
  input wire logic       i_rc_osc_sel,
  input wire logic       i_divided_clock_output_en,
  input wire logic       i_debug_en,
  input wire logic       i_reset_fuse,
  input wire logic       i_debug_data_oe_n,
  input wire logic       i_osc_amp_out,
  input wire logic       o_osc_amp_in,
  input wire logic       o_ext_reset_n,
  input wire logic [7:0] o_pin_interrupt_in,
  input wire logic [7:0] i_pa_pad,
  input wire logic [7:0] o_pa_pad_oe_n,
  input wire logic [5:0] i_pb_pad,
  input wire logic [5:0] o_pb_pad,
  input wire logic [5:0] o_pb_pad_oe_n
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  // the divider is held low while off, so only a held divided_clock_output setting promises a toggle
  wire div_on = i_rc_osc_sel && i_divided_clock_output_en && !i_debug_en;
  mosi_dir_a: assert property (
    i_spi_en |-> o_pa_pad_oe_n[5] == !i_spi_master) else $error("mosi dir");
  sck_dir_a: assert property (
    i_spi_en |-> o_pa_pad_oe_n[7] == !i_spi_master) else $error("sck dir");
  miso_dir_a: assert property (
    i_spi_en |-> o_pa_pad_oe_n[6] == i_spi_master) else $error("miso dir");
  amp_path_a: assert property (
    !i_rc_osc_sel && !i_debug_en |-> !o_pb_pad_oe_n[3] && o_pb_pad_oe_n[2]
    && o_pb_pad[3] == i_osc_amp_out && o_osc_amp_in == i_pb_pad[2])
    else $error("osc amp path");
  clk_div_a: assert property (
    div_on && $past(div_on) |-> o_pb_pad[3] != $past(o_pb_pad[3]))
    else $error("clock out stuck");
  dbg_pin_a: assert property (
    i_debug_en |-> o_pb_pad_oe_n[i_rc_osc_sel ? 2 : 3] == i_debug_data_oe_n)
    else $error("debug data pin");
  ext_rst_a: assert property (
    i_reset_fuse && $past(i_arst_n, 2)
    |-> o_ext_reset_n == $past(i_pa_pad[3], 2)) else $error("reset pin");
  pin_irq_a: assert property (
    $past(i_arst_n, 2) |-> o_pin_interrupt_in == $past(i_pa_pad, 2))
    else $error("pin interrupt");
endmodule
bind pin_function_mux pin_mux_chk chk_u (.*);

// file: far_side_model.sv
`timescale 1ns/1ps
// **************************************
// far side: spi peer, debug host, lines
// **************************************
module far_side_model #(parameter int W = 8) (
  input  wire logic [W-1:0] i_ext,
  input  wire logic [W-1:0] i_dev,
  input  wire logic [W-1:0] i_dev_oe_n,
  output logic      [W-1:0] o_line
);
  // outside drives only released lines, so a wrong direction shows as level
  assign o_line = (i_ext & i_dev_oe_n) | (i_dev & ~i_dev_oe_n);
endmodule

// file: pin_function_mux_test.sv
`timescale 1ns/1ps
// **************
// pin mux bench
// **************
module pin_function_mux_test;
  import pin_mux_pkg::*;
  logic i_mclk, i_arst_n, i_spi_en, i_spi_master, i_rc_osc_sel, i_divided_clock_output_en;
  logic i_debug_en, i_reset_fuse, i_cmp_en, i_serial_en, i_spi_mosi, prev;
  logic i_spi_sck, i_spi_miso, i_osc_amp_out, i_t1_pwm, i_debug_data;
  logic i_debug_data_oe_n, o_spi_mosi, o_spi_sck, o_spi_miso, o_spi_sel_n;
  logic o_osc_amp_in, o_debug_data, o_debug_clk, o_ext_reset_n, o_t1_count;
  logic o_serial_rx, o_cmp_pos, o_cmp_neg;
  t1_mode_e   i_t1_mode;
  logic [7:0] i_pa_out, i_pa_oe_n, o_pa_in, o_pin_interrupt_in, i_pa_pad;
  logic [7:0] o_pa_pad, o_pa_pad_oe_n, ext_a;
  logic [5:0] i_pb_out, i_pb_oe_n, o_pb_in, i_pb_pad, o_pb_pad, ext_b;
  logic [5:0] o_pb_pad_oe_n;
  int         n_mismatch, samples_checked, cycles;
  pin_function_mux dut_u (.*);
  far_side_model #(.W(8)) fa_u (.i_ext(ext_a), .i_dev(o_pa_pad),
    .i_dev_oe_n(o_pa_pad_oe_n), .o_line(i_pa_pad));
  far_side_model #(.W(6)) fb_u (.i_ext(ext_b), .i_dev(o_pb_pad),
    .i_dev_oe_n(o_pb_pad_oe_n), .o_line(i_pb_pad));
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_spi;
    for (int m = 0; m < 2; m++) begin
      {i_spi_en, i_spi_master, ext_a} = {1'b1, m[0], 8'he5};
      {i_spi_sck, i_spi_miso, i_spi_mosi} = {m[0], ~m[0], m[0]};
      tick(3);
      chk(8'(o_pa_pad_oe_n[7:5]), m ? 8'h2 : 8'h5);
      chk(8'(o_pa_pad[7:5] & ~o_pa_pad_oe_n[7:5]),
        m ? 8'h5 : 8'h2);
      chk(8'({o_spi_sck, o_spi_mosi, o_spi_sel_n, o_spi_miso}),
        m ? 8'h3 : 8'hc);
    end
    i_spi_en = 0;
    $display("spi roles done");
  endtask
  task automatic t_osc;
    for (int v = 0; v < 2; v++) begin
      {ext_b, i_osc_amp_out} = {v[0] ? 6'h04 : 6'h00, v[0]};
      tick(1);
      chk(8'({o_pb_pad_oe_n[3:2], o_pb_pad[3], o_osc_amp_in}),
        8'(4+3*v));
    end
    {i_rc_osc_sel, i_divided_clock_output_en} = 2'b11;
    tick(1);
    prev = o_pb_pad[3];
    tick(1);
    chk(8'({o_pb_pad_oe_n[3], o_pb_pad[3] ^ prev}), 8'h1);
    {i_divided_clock_output_en, i_pa_out, i_pb_out, i_pa_oe_n, i_pb_oe_n} = 29'h3ca8000;
    tick(3);
    chk(o_pa_pad, 8'h3c);
    chk(o_pa_pad_oe_n | {2'h0, o_pb_pad_oe_n}, 8'h00);
    chk(8'(o_pb_in), 8'h2a);
    {i_pa_oe_n, i_pb_oe_n} = 14'h3fff;
    $display("oscillator and port pins done");
  endtask
  task automatic t_dbg;
    {i_debug_en, i_debug_data, i_debug_data_oe_n, ext_a} = 11'h608;
    tick(3);
    chk(8'({o_pb_pad_oe_n[2], o_pb_pad[2], o_debug_clk}), 8'h3);
    // released data line low while the other oscillator pin sits high
    {i_debug_data_oe_n, ext_b, ext_a} = 15'h4800;
    tick(3);
    chk(8'({o_debug_data, o_debug_clk}), 8'h0);
    {i_rc_osc_sel, ext_b} = 7'h04;
    tick(3);
    chk(8'({o_pb_pad_oe_n[3:2], o_debug_data}), 8'h6);
    i_debug_data_oe_n = 1'b0;
    tick(3);
    chk(8'({o_pb_pad_oe_n[3], o_pb_pad[3], o_debug_data}), 8'h3);
    {i_debug_en, i_debug_data_oe_n} = 2'b01;
    $display("debug pins done");
  endtask
  task automatic t_misc;
    logic [7:0] t1x [3] = '{8'h48, 8'h15, 8'h0a};
    {i_reset_fuse, i_pb_out, i_pb_oe_n, i_t1_pwm, ext_b} = 20'h80060;
    for (int k = 0; k < 3; k++) begin
      i_t1_mode = t1_mode_e'(k);
      {i_serial_en, i_cmp_en} = {k[0], k[0]};
      ext_a = 8'h09 << k;
      tick(3);
      chk(8'({o_ext_reset_n, o_cmp_pos, o_cmp_neg, o_serial_rx,
        o_pb_pad_oe_n[5], o_pb_pad[5] & ~o_pb_pad_oe_n[5], o_t1_count}),
        t1x[k]);
      chk(o_pin_interrupt_in, ext_a);
      chk(o_pa_in, ext_a);
    end
    {i_reset_fuse, i_pa_out, i_pa_oe_n} = 17'h0;
    tick(1);
    chk(8'({o_ext_reset_n, o_pa_pad_oe_n[3]}), 8'h2);
    $display("fuse timer serial comparator done");
  endtask
  initial begin
    i_mclk = 0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 400) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    {i_arst_n, i_spi_en, i_spi_master, i_rc_osc_sel, i_divided_clock_output_en} = '0;
    {i_debug_en, i_reset_fuse, i_cmp_en, i_serial_en, i_debug_data} = '0;
    {i_spi_mosi, i_spi_sck, i_spi_miso, i_osc_amp_out} = '1;
    {i_debug_data_oe_n, i_pa_oe_n, i_pb_oe_n} = '1;
    {i_t1_pwm, ext_a, ext_b, i_pa_out, i_pb_out} = '0;
    i_t1_mode = T1_PORT;
    tick(16);
    i_arst_n = 1;
    tick(2);
    t_spi();
    t_osc();
    t_dbg();
    t_misc();
    finish_test();
  end
endmodule
